// *** design/pcadc_pkg.sv ***
// shared constants and types for the pin configured converter and its host
package pcadc_pkg;
  // core clock
  localparam int unsigned CORE_CLK_HZ = 25_000_000;
  localparam int unsigned CORE_PERIOD_NS = 40;
  // update rates in millihertz
  localparam int unsigned RATE_SLOW_MHZ = 10_000;
  localparam int unsigned RATE_FAST_MHZ = 16_700;
  // settling and start up times
  localparam int unsigned SETTLE_SLOW_MS = 300;
  localparam int unsigned SETTLE_FAST_MS = 120;
  localparam int unsigned STARTUP_US = 1000;
  localparam int unsigned RST_MIN_NS = 100;
  // counter width, enough for the slow settling count
  localparam int unsigned CNT_W = 23;
  localparam logic [CNT_W-1:0] CONV_CYC_SLOW =
    CNT_W'(64'(CORE_CLK_HZ) * 64'd1000 / 64'(RATE_SLOW_MHZ));
  localparam logic [CNT_W-1:0] CONV_CYC_FAST =
    CNT_W'(64'(CORE_CLK_HZ) * 64'd1000 / 64'(RATE_FAST_MHZ));
  localparam logic [CNT_W-1:0] SETTLE_CYC_SLOW =
    CNT_W'(64'(CORE_CLK_HZ / 1000) * 64'(SETTLE_SLOW_MS));
  localparam logic [CNT_W-1:0] SETTLE_CYC_FAST =
    CNT_W'(64'(CORE_CLK_HZ / 1000) * 64'(SETTLE_FAST_MS));
  localparam logic [CNT_W-1:0] STARTUP_CYC =
    CNT_W'(64'(CORE_CLK_HZ / 1_000_000) * 64'(STARTUP_US));
  localparam logic [3:0] RST_MIN_CYC =
    4'((RST_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
  // serial word
  localparam int unsigned RESULT_W = 24;
  localparam int unsigned STATUS_W = 8;
  localparam int unsigned WORD_W = 32;
  localparam logic [5:0] WORD_BITS = 6'h20;
  // status byte field positions
  localparam int unsigned ST_RDY = 7;
  localparam int unsigned ST_ZERO = 6;
  localparam int unsigned ST_ERR = 5;
  localparam int unsigned ST_ID_HI = 4;
  localparam int unsigned ST_ID_LO = 3;
  localparam int unsigned ST_FILTER = 2;
  localparam int unsigned ST_GAIN = 1;
  localparam int unsigned ST_PAT = 0;
  // pin synchroniser slots
  localparam int unsigned SYNC_N = 4;
  localparam int unsigned PIN_POWER_DOWN_RESET_N = 0;
  localparam int unsigned PIN_FILTER = 1;
  localparam int unsigned PIN_GAIN = 2;
  localparam int unsigned PIN_DONE = 3;
  // host serial clock divider
  localparam logic [4:0] SCLK_HALF_CYC = 5'h08;
  localparam logic [4:0] IDLE_GUARD_CYC = 5'h10;
  localparam logic [5:0] RST_HALVES = 6'h04;
  typedef enum logic [1:0] {
    PCADC_PD, PCADC_START, PCADC_SETTLE, PCADC_RUN
  } pcadc_state_t;
  typedef enum logic [2:0] {
    PCADC_H_RST, PCADC_H_PD, PCADC_H_IDLE, PCADC_H_LOW, PCADC_H_HIGH
  } pcadc_hstate_t;
endpackage

// *** design/pcadc_if.sv ***
// pins between the converter and its host controller
`timescale 1ns/100ps
interface pcadc_if;
  logic sclk;
  logic dout;
  logic dout_oe;
  logic power_down_reset_n;
  logic filter_sel;
  logic gain_sel;
  logic dout_line;
  // released line floats high through the pull up
  assign dout_line = dout_oe ? dout : 1'b1;
  modport dev (
    input sclk,
    input power_down_reset_n,
    input filter_sel,
    input gain_sel,
    output dout,
    output dout_oe
  );
  modport host (
    output sclk,
    output power_down_reset_n,
    output filter_sel,
    output gain_sel,
    input dout_line
  );
endinterface

// *** design/pcadc_dev.sv ***
// converter end: pin decode, conversion sequencing and serial read port
`timescale 1ns/100ps
module pcadc_dev #(
  parameter logic [pcadc_pkg::CNT_W-1:0] CONV_CYC_SLOW =
    pcadc_pkg::CONV_CYC_SLOW,
  parameter logic [pcadc_pkg::CNT_W-1:0] CONV_CYC_FAST =
    pcadc_pkg::CONV_CYC_FAST,
  parameter logic [pcadc_pkg::CNT_W-1:0] SETTLE_CYC_SLOW =
    pcadc_pkg::SETTLE_CYC_SLOW,
  parameter logic [pcadc_pkg::CNT_W-1:0] SETTLE_CYC_FAST =
    pcadc_pkg::SETTLE_CYC_FAST,
  parameter logic [pcadc_pkg::CNT_W-1:0] STARTUP_CYC =
    pcadc_pkg::STARTUP_CYC,
  // value is arbitrary
  parameter logic [1:0] STATUS_ID = 2'h2
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  pcadc_if.dev link,
  input wire logic [pcadc_pkg::RESULT_W-1:0] conv_code_i,
  input wire logic range_err_i,
  output logic gain_x128_o,
  output logic filter_slow_o,
  output logic osc_run_o,
  output logic modulator_run_o,
  output logic bridge_supply_switch_o,
  output logic [pcadc_pkg::RESULT_W-1:0] result_o,
  output logic conv_done_o
);
  pcadc_pkg::pcadc_state_t state;
  logic [pcadc_pkg::SYNC_N-1:0] pin_raw;
  logic [pcadc_pkg::SYNC_N-1:0] pin_s1;
  logic [pcadc_pkg::SYNC_N-1:0] pin_s2;
  logic [pcadc_pkg::SYNC_N-1:0] pin_s3;
  logic [pcadc_pkg::SYNC_N-1:0] pin_q;
  logic pd_n;
  logic filt;
  logic gain;
  logic [1:0] cfg_prev;
  logic cfg_chg;
  logic done_seen;
  logic done_evt;
  logic [pcadc_pkg::CNT_W-1:0] cnt;
  logic [pcadc_pkg::CNT_W-1:0] settle_end;
  logic [pcadc_pkg::CNT_W-1:0] period_end;
  logic conv_evt;
  logic pre_evt;
  logic ready;
  logic [pcadc_pkg::WORD_W-1:0] word;
  logic [pcadc_pkg::STATUS_W-1:0] status;
  logic word_tag;
  // serial clock domain
  logic [5:0] bit_cnt;
  logic [pcadc_pkg::WORD_W-1:0] shreg;
  logic tag_seen;
  logic frame_par;
  logic done_par;
  logic done_tgl;
  logic frame_open;

  assign pin_raw = {done_tgl, link.gain_sel, link.filter_sel,
                    link.power_down_reset_n};

  // three stage synchronisers; a change counts once stages two and three agree
  for (genvar i = 0; i < pcadc_pkg::SYNC_N; i++) begin : g_sync
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        pin_s1[i] <= 1'b0;
        pin_s2[i] <= 1'b0;
        pin_s3[i] <= 1'b0;
        pin_q[i] <= 1'b0;
      end else begin
        pin_s1[i] <= pin_raw[i];
        pin_s2[i] <= pin_s1[i];
        pin_s3[i] <= pin_s2[i];
        if (pin_s2[i] == pin_s3[i]) begin
          pin_q[i] <= pin_s3[i];
        end
      end
    end
  end

  assign pd_n = pin_q[pcadc_pkg::PIN_POWER_DOWN_RESET_N];
  assign filt = pin_q[pcadc_pkg::PIN_FILTER];
  assign gain = pin_q[pcadc_pkg::PIN_GAIN];
  assign cfg_chg = ({gain, filt} != cfg_prev);
  assign done_evt = (pin_q[pcadc_pkg::PIN_DONE] != done_seen);

  // update period and settling follow the filter pin
  assign settle_end = filt ? SETTLE_CYC_SLOW - 1'b1
                           : SETTLE_CYC_FAST - 1'b1;
  assign period_end = filt ? CONV_CYC_SLOW - 1'b1
                           : CONV_CYC_FAST - 1'b1;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cfg_prev <= 2'h0;
      done_seen <= 1'b0;
    end else begin
      cfg_prev <= {gain, filt};
      done_seen <= pin_q[pcadc_pkg::PIN_DONE];
    end
  end

  // power up reset and the pin both land in power down
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !pd_n) begin
      state <= pcadc_pkg::PCADC_PD;
    end else begin
      unique case (state)
        pcadc_pkg::PCADC_PD: begin
          state <= pcadc_pkg::PCADC_START;
        end
        pcadc_pkg::PCADC_START: begin
          if (cnt == STARTUP_CYC - 1'b1) begin
            state <= pcadc_pkg::PCADC_SETTLE;
          end
        end
        pcadc_pkg::PCADC_SETTLE: begin
          if (!cfg_chg && cnt == settle_end) begin
            state <= pcadc_pkg::PCADC_RUN;
          end
        end
        pcadc_pkg::PCADC_RUN: begin
          if (cfg_chg) begin
            state <= pcadc_pkg::PCADC_SETTLE;
          end
        end
      endcase
    end
  end

  // a filter or gain change restarts the count at once in settle and run, even mid conversion
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !pd_n) begin
      cnt <= '0;
    end else begin
      unique case (state)
        pcadc_pkg::PCADC_PD: begin
          cnt <= '0;
        end
        pcadc_pkg::PCADC_START: begin
          cnt <= (cnt == STARTUP_CYC - 1'b1) ? '0 : cnt + 1'b1;
        end
        pcadc_pkg::PCADC_SETTLE: begin
          cnt <= (cfg_chg || cnt == settle_end) ? '0 : cnt + 1'b1;
        end
        pcadc_pkg::PCADC_RUN: begin
          cnt <= (cfg_chg || cnt == period_end) ? '0 : cnt + 1'b1;
        end
      endcase
    end
  end

  assign conv_evt = !cfg_chg && (
    (state == pcadc_pkg::PCADC_SETTLE && cnt == settle_end) ||
    (state == pcadc_pkg::PCADC_RUN && cnt == period_end));
  // one cycle warning so a read never overlaps the update
  assign pre_evt = !cfg_chg && state == pcadc_pkg::PCADC_RUN &&
                   cnt == period_end - 1'b1;

  // a fresh result wins over a read-done clear in the same cycle; a config change cancels the result; power down wins over both
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !pd_n) begin
      ready <= 1'b0;
    end else if (conv_evt) begin
      ready <= 1'b1;
    end else if (pre_evt || cfg_chg || done_evt) begin
      ready <= 1'b0;
    end
  end

  always_comb begin
    status = '0;
    status[pcadc_pkg::ST_RDY] = 1'b0;
    status[pcadc_pkg::ST_ERR] = range_err_i;
    status[pcadc_pkg::ST_ID_HI] = STATUS_ID[1];
    status[pcadc_pkg::ST_ID_LO] = STATUS_ID[0];
    status[pcadc_pkg::ST_FILTER] = filt;
    status[pcadc_pkg::ST_GAIN] = gain;
  end

  // tag flips on every new word and on power down, so a stale half read
  // in the serial domain is dropped at its next edge
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      word <= '0;
      word_tag <= 1'b0;
      conv_done_o <= 1'b0;
    end else begin
      conv_done_o <= conv_evt;
      if (conv_evt) begin
        word <= {conv_code_i, status};
        word_tag <= ~word_tag;
      end else if (!pd_n && state != pcadc_pkg::PCADC_PD) begin
        word_tag <= ~word_tag;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      osc_run_o <= 1'b0;
      modulator_run_o <= 1'b0;
      bridge_supply_switch_o <= 1'b0;
      gain_x128_o <= 1'b1;
      filter_slow_o <= 1'b0;
    end else begin
      osc_run_o <= pd_n;
      modulator_run_o <= !cfg_chg && pd_n &&
        (state == pcadc_pkg::PCADC_SETTLE ||
         state == pcadc_pkg::PCADC_RUN);
      bridge_supply_switch_o <= pd_n &&
        state != pcadc_pkg::PCADC_PD;
      gain_x128_o <= !gain;
      filter_slow_o <= filt;
    end
  end

  // serial side: bits change on the falling edge, host samples before rise
  always_ff @(negedge link.sclk) begin
    if (!link.power_down_reset_n) begin
      bit_cnt <= '0;
      shreg <= '0;
      tag_seen <= 1'b0;
      frame_par <= 1'b0;
    end else if (bit_cnt == '0 || bit_cnt == pcadc_pkg::WORD_BITS ||
                 tag_seen != word_tag) begin
      // word is quiet while ready stands, so it is taken directly
      shreg <= word;
      bit_cnt <= 6'h01;
      tag_seen <= word_tag;
      frame_par <= ~frame_par;
    end else begin
      shreg <= {shreg[pcadc_pkg::WORD_W-2:0], 1'b0};
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // last bit shows on the pin only from the rise that follows it until the core sees it; that rise reports it once
  always_ff @(posedge link.sclk) begin
    if (!link.power_down_reset_n) begin
      done_par <= 1'b0;
      done_tgl <= 1'b0;
    end else if (bit_cnt == pcadc_pkg::WORD_BITS && done_par != frame_par) begin
      done_par <= frame_par;
      done_tgl <= ~done_tgl;
    end
  end

  assign frame_open = bit_cnt != '0 && tag_seen == word_tag &&
    (bit_cnt != pcadc_pkg::WORD_BITS ||
     done_tgl != done_seen);
  // outside a frame the pin is the inverted ready flag
  assign link.dout = frame_open ? shreg[pcadc_pkg::WORD_W-1]
                                : !ready;
  assign link.dout_oe = (state != pcadc_pkg::PCADC_PD);
  assign result_o = word[pcadc_pkg::WORD_W-1:pcadc_pkg::STATUS_W];
endmodule

// *** design/pcadc_host.sv ***
// host end: drives the config pins and clocks out each ready word
`timescale 1ns/100ps
module pcadc_host (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  pcadc_if.host link,
  input wire logic power_down_req_i,
  input wire logic filter_slow_i,
  input wire logic gain_unity_i,
  output logic [pcadc_pkg::RESULT_W-1:0] word_o,
  output logic [pcadc_pkg::STATUS_W-1:0] status_o,
  output logic word_valid_o,
  output logic busy_o
);
  pcadc_pkg::pcadc_hstate_t state;
  logic d_s1;
  logic d_s2;
  logic d_s3;
  logic d_q;
  logic [4:0] hc;
  logic [5:0] nb;
  logic [3:0] pd_cnt;
  logic [pcadc_pkg::WORD_W-1:0] sh;
  logic sclk;
  logic filt;
  logic gain;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      d_s1 <= 1'b1;
      d_s2 <= 1'b1;
      d_s3 <= 1'b1;
      d_q <= 1'b1;
    end else begin
      d_s1 <= link.dout_line;
      d_s2 <= d_s1;
      d_s3 <= d_s2;
      if (d_s2 == d_s3) begin
        d_q <= d_s3;
      end
    end
  end

  // reset state pulses the serial clock so the far end clears its counters
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state <= pcadc_pkg::PCADC_H_RST;
      hc <= '0;
      nb <= '0;
      pd_cnt <= '0;
      sclk <= 1'b1;
      sh <= '0;
      filt <= 1'b0;
      gain <= 1'b0;
      word_o <= '0;
      status_o <= '0;
      word_valid_o <= 1'b0;
    end else begin
      word_valid_o <= 1'b0;
      unique case (state)
        pcadc_pkg::PCADC_H_RST: begin
          hc <= hc + 1'b1;
          if (hc == pcadc_pkg::SCLK_HALF_CYC - 1'b1) begin
            hc <= '0;
            sclk <= ~sclk;
            nb <= nb + 1'b1;
            if (nb == pcadc_pkg::RST_HALVES - 1'b1) begin
              state <= pcadc_pkg::PCADC_H_PD;
              sclk <= 1'b1;
              nb <= '0;
            end
          end
        end
        pcadc_pkg::PCADC_H_PD: begin
          // low for at least the reset minimum
          if (pd_cnt != pcadc_pkg::RST_MIN_CYC) begin
            pd_cnt <= pd_cnt + 1'b1;
          end else if (!power_down_req_i) begin
            state <= pcadc_pkg::PCADC_H_IDLE;
            hc <= '0;
          end
        end
        pcadc_pkg::PCADC_H_IDLE: begin
          // pins only move here, between reads
          filt <= filter_slow_i;
          gain <= gain_unity_i;
          if (filt != filter_slow_i || gain != gain_unity_i) begin
            hc <= '0;
          end else if (hc != pcadc_pkg::IDLE_GUARD_CYC) begin
            hc <= hc + 1'b1;
          end
          if (power_down_req_i) begin
            state <= pcadc_pkg::PCADC_H_PD;
            pd_cnt <= '0;
          end else if (hc == pcadc_pkg::IDLE_GUARD_CYC && !d_q) begin
            state <= pcadc_pkg::PCADC_H_LOW;
            sclk <= 1'b0;
            hc <= '0;
            nb <= '0;
          end
        end
        pcadc_pkg::PCADC_H_LOW: begin
          hc <= hc + 1'b1;
          if (hc == pcadc_pkg::SCLK_HALF_CYC - 1'b1) begin
            sh <= {sh[pcadc_pkg::WORD_W-2:0], d_q};
            nb <= nb + 1'b1;
            sclk <= 1'b1;
            hc <= '0;
            state <= pcadc_pkg::PCADC_H_HIGH;
          end
        end
        pcadc_pkg::PCADC_H_HIGH: begin
          hc <= hc + 1'b1;
          if (hc == pcadc_pkg::SCLK_HALF_CYC - 1'b1) begin
            hc <= '0;
            if (nb == pcadc_pkg::WORD_BITS) begin
              word_o <= sh[pcadc_pkg::WORD_W-1:pcadc_pkg::STATUS_W];
              status_o <= sh[pcadc_pkg::STATUS_W-1:0];
              word_valid_o <= 1'b1;
              state <= pcadc_pkg::PCADC_H_IDLE;
            end else begin
              sclk <= 1'b0;
              state <= pcadc_pkg::PCADC_H_LOW;
            end
          end
        end
        default: begin
          state <= pcadc_pkg::PCADC_H_RST;
        end
      endcase
    end
  end

  assign link.sclk = sclk;
  assign link.filter_sel = filt;
  assign link.gain_sel = gain;
  assign link.power_down_reset_n = (state != pcadc_pkg::PCADC_H_RST &&
                                    state != pcadc_pkg::PCADC_H_PD);
  assign busy_o = (state == pcadc_pkg::PCADC_H_LOW ||
                   state == pcadc_pkg::PCADC_H_HIGH);
endmodule

// *** dv/pcadc_chk.sv ***
// assertion checker watching the pins between converter and host
`timescale 1ns/100ps
module pcadc_chk #(
  parameter int SETTLE_MIN = 1800
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic sclk,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic power_down_reset_n,
  input wire logic filter_sel,
  input wire logic gain_sel,
  input wire logic dout_line
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [12:0] since_chg;
  logic [5:0] rise_cnt;
  logic filt_q;
  logic gain_q;
  logic sclk_q;
  // restarts on wake or any filter or gain pin change, saturates at the shortest settle
  always_ff @(posedge core_clk_i) begin
    filt_q <= filter_sel;
    gain_q <= gain_sel;
    if (sys_rst_i || !power_down_reset_n || filter_sel != filt_q ||
        gain_sel != gain_q) begin
      since_chg <= 13'h0000;
    end else if (since_chg < 13'(SETTLE_MIN)) begin
      since_chg <= since_chg + 13'h0001;
    end
  end
  // rising serial clock edges of one word; power down aborts the word
  always_ff @(posedge core_clk_i) begin
    sclk_q <= sclk;
    if (sys_rst_i || !power_down_reset_n || rise_cnt == 6'h20) begin
      rise_cnt <= 6'h00;
    end else if (sclk && !sclk_q) begin
      rise_cnt <= rise_cnt + 6'h01;
    end
  end
  sequence s_low_half;
    !sclk [*8] ##1 sclk;
  endsequence
  sequence s_held_high;
    dout_line [*8];
  endsequence
  property p_pd_release;
    $fell(power_down_reset_n) |-> ##[1:6] !dout_oe;
  endproperty
  property p_pd_hold;
    !power_down_reset_n [*6] |-> !dout_oe;
  endproperty
  property p_wake_drive;
    $rose(power_down_reset_n) |-> ##[1:8] (dout_oe && dout);
  endproperty
  property p_settle_high;
    power_down_reset_n && since_chg >= 13'h0008 &&
      since_chg < 13'(SETTLE_MIN) |-> dout_line;
  endproperty
  property p_filter_restart;
    $changed(filter_sel) && power_down_reset_n |-> ##8 s_held_high;
  endproperty
  property p_gain_restart;
    $changed(gain_sel) && power_down_reset_n |-> ##8 s_held_high;
  endproperty
  property p_half_period;
    $fell(sclk) |-> s_low_half;
  endproperty
  property p_read_done;
    rise_cnt == 6'h20 |-> ##[1:8] dout_line;
  endproperty
  // host needs four cycles through its synchroniser before the first fall
  property p_ready_waits;
    $fell(dout_line) && sclk |-> !dout_line [*4];
  endproperty
  a_pd_release: assert property (p_pd_release)
    else $error("output still driven after power down");
  a_pd_hold: assert property (p_pd_hold)
    else $error("output driven while powered down");
  a_wake_drive: assert property (p_wake_drive)
    else $error("output not driven after wake");
  a_settle_high: assert property (p_settle_high)
    else $error("ready seen before settling");
  a_filter_restart: assert property (p_filter_restart)
    else $error("filter change did not raise ready");
  a_gain_restart: assert property (p_gain_restart)
    else $error("gain change did not raise ready");
  a_half_period: assert property (p_half_period)
    else $error("serial clock low phase wrong");
  a_read_done: assert property (p_read_done)
    else $error("ready not cleared after read");
  a_ready_waits: assert property (p_ready_waits)
    else $error("ready dropped too early");
endmodule

// *** dv/test_pin_configured_adc_sequencer.sv ***
// self checking bench for converter and host joined at the pins
`timescale 1ns/100ps
module test_pin_configured_adc_sequencer;
  localparam logic [22:0] C_SLOW = 23'h0005DC;
  localparam logic [22:0] C_FAST = 23'h000384;
  localparam logic [22:0] S_SLOW = 23'h001194;
  localparam logic [22:0] S_FAST = 23'h000708;
  localparam logic [22:0] START = 23'h000032;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic power_down_req_i = 1'b1;
  logic filter_slow_i = 1'b0;
  logic gain_unity_i = 1'b0;
  logic [23:0] conv_code_i = 24'hA5C31E;
  logic range_err_i = 1'b0;
  logic gain_x128_o, filter_slow_o, osc_run_o, modulator_run_o;
  logic bridge_supply_switch_o, conv_done_o, word_valid_o, busy_o;
  logic [23:0] result_o;
  logic [23:0] word_o;
  logic [7:0] status_o;
  int fails = 0;
  int check_count = 0;
  pcadc_if link ();
  pcadc_dev #(.CONV_CYC_SLOW(C_SLOW), .CONV_CYC_FAST(C_FAST),
    .SETTLE_CYC_SLOW(S_SLOW), .SETTLE_CYC_FAST(S_FAST),
    .STARTUP_CYC(START), .STATUS_ID(2'h2)) pcadc_dev_inst (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .link(link),
    .conv_code_i(conv_code_i), .range_err_i(range_err_i),
    .gain_x128_o(gain_x128_o), .filter_slow_o(filter_slow_o),
    .osc_run_o(osc_run_o), .modulator_run_o(modulator_run_o),
    .bridge_supply_switch_o(bridge_supply_switch_o),
    .result_o(result_o), .conv_done_o(conv_done_o));
  pcadc_host pcadc_host_inst (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .link(link),
    .power_down_req_i(power_down_req_i), .filter_slow_i(filter_slow_i),
    .gain_unity_i(gain_unity_i), .word_o(word_o), .status_o(status_o),
    .word_valid_o(word_valid_o), .busy_o(busy_o));
  pcadc_chk #(.SETTLE_MIN(1800)) pcadc_chk_inst (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .sclk(link.sclk),
    .dout(link.dout), .dout_oe(link.dout_oe),
    .power_down_reset_n(link.power_down_reset_n),
    .filter_sel(link.filter_sel), .gain_sel(link.gain_sel),
    .dout_line(link.dout_line));
  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // bounded so a part that never gets ready cannot hang the run
  task automatic time_ready(output int n);
    n = 0;
    while (link.dout_line !== 1'b0 && n < 20000) begin
      @(negedge core_clk_i);
      n++;
    end
  endtask
  task automatic conv_gap(output int n);
    n = 0;
    while (conv_done_o !== 1'b1 && n < 3000) begin
      @(negedge core_clk_i);
    end
    @(negedge core_clk_i);
    while (conv_done_o !== 1'b1 && n < 3000) begin
      @(negedge core_clk_i);
      n++;
    end
    n++;
  endtask
  // gain status bit follows the gain pin level, like the filter bit
  task automatic get_word(input logic [23:0] code, input logic err,
                          input logic slow);
    int n;
    n = 0;
    while (word_valid_o !== 1'b1 && n < 2000) begin
      @(negedge core_clk_i);
      n++;
    end
    check(32'(word_valid_o), 32'h1);
    check({word_o, status_o}, {code, 2'h0, err, 2'h2, slow,
      gain_unity_i, 1'b0});
    check(32'(result_o), 32'(code));
  endtask
  task automatic in_window(input int n, input int lo);
    check(32'(n >= lo && n <= lo + 25), 32'h1);
  endtask
  initial begin
    repeat (40000) @(posedge core_clk_i);
    fails++;
    finish_test();
  end
  initial begin
    int n;
    repeat (5) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    repeat (100) @(negedge core_clk_i);
    check(32'({bridge_supply_switch_o, link.dout_oe, osc_run_o,
      modulator_run_o, link.dout_line}), 32'h01);
    power_down_req_i = 1'b0;
    time_ready(n);
    in_window(n, int'(START + S_FAST));
    check(32'({bridge_supply_switch_o, link.dout_oe, osc_run_o,
      filter_slow_o, gain_x128_o}), 32'h1D);
    // host has begun clocking the word out by now
    repeat (8) @(negedge core_clk_i);
    check(32'({busy_o, modulator_run_o}), 32'h3);
    get_word(24'hA5C31E, 1'b0, 1'b0);
    conv_code_i = 24'h5A3CE1;
    range_err_i = 1'b1;
    conv_gap(n);
    check(32'(n), 32'(C_FAST));
    // one word after the code step is skipped inside conv_gap
    get_word(24'h5A3CE1, 1'b1, 1'b0);
    // change lands on a waiting result, host idle, no read in progress
    time_ready(n);
    filter_slow_i = 1'b1;
    range_err_i = 1'b0;
    conv_code_i = 24'h0F00F1;
    repeat (8) @(negedge core_clk_i);
    check(32'(link.dout_line), 32'h1);
    time_ready(n);
    in_window(n + 8, int'(S_SLOW));
    check(32'(filter_slow_o), 32'h1);
    get_word(24'h0F00F1, 1'b0, 1'b1);
    conv_code_i = 24'hFFFFFE;
    conv_gap(n);
    check(32'(n), 32'(C_SLOW));
    get_word(24'hFFFFFE, 1'b0, 1'b1);
    gain_unity_i = 1'b1;
    conv_code_i = 24'h000001;
    time_ready(n);
    in_window(n, int'(S_SLOW));
    check(32'(gain_x128_o), 32'h0);
    get_word(24'h000001, 1'b0, 1'b1);
    // held far beyond the minimum low time
    power_down_req_i = 1'b1;
    repeat (20) @(negedge core_clk_i);
    check(32'({bridge_supply_switch_o, link.dout_oe, osc_run_o,
      link.dout_line}), 32'h1);
    power_down_req_i = 1'b0;
    time_ready(n);
    in_window(n, int'(START + S_SLOW));
    get_word(24'h000001, 1'b0, 1'b1);
    finish_test();
  end
endmodule
